// ===== rtl/pacs_cfg.svh
// Purpose: constants for the page address and emulation select decode
// Assumes: 16-bit physical address, six page index bits
// Notes: region codes taken from the top two address bits
`ifndef PACS_CFG_SVH
`define PACS_CFG_SVH
`define PACS_REGION_LSB 14
`define PACS_XADDR_LOW0 6'h3d
`define PACS_XADDR_LOW1 6'h3e
`define PACS_XADDR_TOP 6'h3f
`define PACS_THRESH_128K 6'h38
`define PACS_THRESH_256K 6'h30
`define PACS_THRESH_512K 6'h20
`define PACS_THRESH_1M 6'h00
`define PACS_APB_CTRL 12'h000
`define PACS_APB_STAT 12'h004
`define PACS_CTRL_RST 32'h0000_0000
`define PACS_PORTK_OUT_RST 8'hff
`define PACS_PORTK_OE_RST 8'h00
`endif

// ===== rtl/pacs_pkg.sv
// Purpose: types for the page address and emulation select decode
// Assumes: used by pacs_decode only
// Notes: constants live in pacs_cfg.svh
package pacs_pkg;
  typedef enum logic [1:0] {
    ALLOC_0K,
    ALLOC_16K,
    ALLOC_48K,
    ALLOC_64K
  } pacs_alloc_type;
  typedef enum logic [1:0] {
    REG_LOW0,
    REG_LOW1,
    REG_WINDOW,
    REG_TOP
  } pacs_region_type;
  typedef struct packed {
    logic [5:0] xaddr;
    logic selN;
    logic enable;
  } pacs_out_type;
endpackage

// ===== rtl/pacs_decode.sv
// Purpose: extended address and emulation select decode with APB control
// Assumes: bus address and page index synchronous to clk
// Notes: outputs registered, one cycle after the bus cycle address
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "pacs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pacs_decode (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] busAddr,
  input wire logic expandedMode,
  input wire logic [5:0] programPageIndex,
  input wire logic [1:0] pagePartitionSelect,
  input wire logic [6:0] portKGpioOut,
  input wire logic [7:0] portKGpioDir,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] portKOut,
  output logic [7:0] portKOe
);
  // ctrl: bit0 option, bits2:1 allocation, bit3 hide
  logic [31:0] ctrl_q;
  logic emulationPortOption;
  logic lowerFlashMapHide;
  pacs_pkg::pacs_alloc_type alloc;
  pacs_pkg::pacs_region_type region;
  pacs_pkg::pacs_out_type dec;
  logic [5:0] thresh;
  logic winInternal;
  logic active;
  logic apbAccess;
  logic apbDone;
  logic [31:0] prdata_d;
  logic pslverr_d;

  assign emulationPortOption = ctrl_q[0];
  assign alloc = pacs_pkg::pacs_alloc_type'(ctrl_q[2:1]);
  assign lowerFlashMapHide = ctrl_q[3];
  assign active = emulationPortOption & expandedMode;
  assign region = pacs_pkg::pacs_region_type'(busAddr[15:`PACS_REGION_LSB]);
  assign apbAccess = psel & penable & ~pready;
  // completing edge: pready seen high by the master
  assign apbDone = psel & penable & pready;

  always_comb begin
    case (pagePartitionSelect)
      2'b00: thresh = `PACS_THRESH_128K;
      2'b01: thresh = `PACS_THRESH_256K;
      2'b10: thresh = `PACS_THRESH_512K;
      default: thresh = `PACS_THRESH_1M;
    endcase
    winInternal = (programPageIndex >= thresh);
  end

  always_comb begin
    dec.enable = active;
    dec.selN = 1'b1;
    dec.xaddr = `PACS_XADDR_TOP;
    case (region)
      pacs_pkg::REG_LOW0: begin
        dec.xaddr = `PACS_XADDR_LOW0;
        if (alloc == pacs_pkg::ALLOC_64K) begin
          dec.selN = lowerFlashMapHide;
        end
      end
      pacs_pkg::REG_LOW1: begin
        dec.xaddr = `PACS_XADDR_LOW1;
        if (alloc == pacs_pkg::ALLOC_48K || alloc == pacs_pkg::ALLOC_64K) begin
          dec.selN = lowerFlashMapHide;
        end
      end
      pacs_pkg::REG_WINDOW: begin
        dec.xaddr = programPageIndex;
        case (alloc)
          pacs_pkg::ALLOC_0K: dec.selN = 1'b0;
          pacs_pkg::ALLOC_16K: dec.selN = 1'b1;
          default: dec.selN = ~winInternal;
        endcase
      end
      default: begin
        dec.xaddr = `PACS_XADDR_TOP;
        dec.selN = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portKOut <= `PACS_PORTK_OUT_RST;
      portKOe <= `PACS_PORTK_OE_RST;
    end else if (dec.enable) begin
      portKOut <= {dec.selN, portKGpioOut[6], dec.xaddr};
      portKOe <= {1'b1, portKGpioDir[6], 6'h3f};
    end else if (emulationPortOption) begin
      portKOut <= {1'b1, portKGpioOut[6], portKGpioOut[5:0]};
      portKOe <= {1'b1, portKGpioDir[6:0]};
    end else begin
      portKOut <= {1'b0, portKGpioOut};
      portKOe <= portKGpioDir;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `PACS_CTRL_RST;
    end else if (apbDone && pwrite && paddr == `PACS_APB_CTRL) begin
      ctrl_q <= {28'h0000000, pwdata[3:0]};
    end
  end

  always_comb begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (paddr == `PACS_APB_CTRL) begin
      prdata_d = ctrl_q;
    end else if (paddr == `PACS_APB_STAT) begin
      prdata_d = {23'h000000, winInternal, dec.enable, dec.selN, dec.xaddr};
      pslverr_d = pwrite;
    end else begin
      pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess & pslverr_d;
      prdata <= (apbAccess && !pwrite) ? prdata_d : 32'h0000_0000;
    end
  end

  property p_top_sel;
    @(posedge clk) disable iff (sys_rst)
    (active && region == pacs_pkg::REG_TOP) |=> (portKOut[7] == 1'b0 && portKOe[7]);
  endproperty
  a_top_sel: assert property (p_top_sel)
    else $error("top block select not low");

  property p_win_addr;
    @(posedge clk) disable iff (sys_rst)
    (active && region == pacs_pkg::REG_WINDOW) |=> portKOut[5:0] == $past(programPageIndex);
  endproperty
  a_win_addr: assert property (p_win_addr)
    else $error("window address not page index");

  property p_low0_addr;
    @(posedge clk) disable iff (sys_rst)
    (active && region == pacs_pkg::REG_LOW0) |=> portKOut[5:0] == 6'h3d;
  endproperty
  a_low0_addr: assert property (p_low0_addr)
    else $error("low block address wrong");

  property p_low1_addr;
    @(posedge clk) disable iff (sys_rst)
    (active && region == pacs_pkg::REG_LOW1) |=> portKOut[5:0] == 6'h3e;
  endproperty
  a_low1_addr: assert property (p_low1_addr)
    else $error("second block address wrong");

  property p_top_addr;
    @(posedge clk) disable iff (sys_rst)
    (active && region == pacs_pkg::REG_TOP) |=> portKOut[5:0] == 6'h3f;
  endproperty
  a_top_addr: assert property (p_top_addr)
    else $error("top block address wrong");

  property p_off;
    @(posedge clk) disable iff (sys_rst)
    !active |=> portKOe[5:0] == $past(portKGpioDir[5:0]);
  endproperty
  a_off: assert property (p_off)
    else $error("pins driven while inactive");

  property p_0k_low;
    @(posedge clk) disable iff (sys_rst)
    (active && alloc == pacs_pkg::ALLOC_0K
      && (region == pacs_pkg::REG_LOW0 || region == pacs_pkg::REG_LOW1)) |=> portKOut[7];
  endproperty
  a_0k_low: assert property (p_0k_low)
    else $error("0K select low in low blocks");

  property p_16k_win;
    @(posedge clk) disable iff (sys_rst)
    (active && alloc == pacs_pkg::ALLOC_16K && region != pacs_pkg::REG_TOP) |=> portKOut[7];
  endproperty
  a_16k_win: assert property (p_16k_win)
    else $error("16K select low outside top");

  property p_hide;
    @(posedge clk) disable iff (sys_rst)
    (active && alloc == pacs_pkg::ALLOC_48K && region == pacs_pkg::REG_LOW1)
      |=> portKOut[7] == $past(lowerFlashMapHide);
  endproperty
  a_hide: assert property (p_hide)
    else $error("48K hide select wrong");

  property p_48k_low0;
    @(posedge clk) disable iff (sys_rst)
    (active && alloc == pacs_pkg::ALLOC_48K && region == pacs_pkg::REG_LOW0) |=> portKOut[7];
  endproperty
  a_48k_low0: assert property (p_48k_low0)
    else $error("48K first block select low");

  property p_64k_low0;
    @(posedge clk) disable iff (sys_rst)
    (active && alloc == pacs_pkg::ALLOC_64K && region == pacs_pkg::REG_LOW0)
      |=> portKOut[7] == $past(lowerFlashMapHide);
  endproperty
  a_64k_low0: assert property (p_64k_low0)
    else $error("64K hide select wrong");

  property p_ext_win;
    @(posedge clk) disable iff (sys_rst)
    (active && alloc == pacs_pkg::ALLOC_64K && region == pacs_pkg::REG_WINDOW
      && pagePartitionSelect == 2'b01 && programPageIndex < 6'h30) |=> portKOut[7];
  endproperty
  a_ext_win: assert property (p_ext_win)
    else $error("external window select low");

  property p_int_win;
    @(posedge clk) disable iff (sys_rst)
    (active && (alloc == pacs_pkg::ALLOC_48K || alloc == pacs_pkg::ALLOC_64K)
      && region == pacs_pkg::REG_WINDOW && pagePartitionSelect == 2'b00
      && programPageIndex >= 6'h38) |=> !portKOut[7];
  endproperty
  a_int_win: assert property (p_int_win)
    else $error("internal window select high");

  property p_gpio;
    @(posedge clk) disable iff (sys_rst)
    !emulationPortOption |=> (portKOe == $past(portKGpioDir)
      && portKOut[6:0] == $past(portKGpioOut));
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("port K not plain I/O");

  property p_apb;
    @(posedge clk) disable iff (sys_rst)
    (psel && !penable) |=> ##1 pready;
  endproperty
  a_apb: assert property (p_apb)
    else $error("apb not answered");
endmodule
`default_nettype wire

// ===== verification/pacs_emu_model.sv
// Purpose: far-side model of the emulator pins on port K
// Assumes: every port K pin has a pull-up
// Notes: select is active low on bit 7
`timescale 1ns/1ps
`default_nettype none
module pacs_emu_model (
  input wire logic [7:0] portKOut,
  input wire logic [7:0] portKOe,
  output logic [7:0] pinLevel
);
  // undriven pins float high, select read on bit 7
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinLevel[i] = portKOe[i] ? portKOut[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/pacs_decode_tb_top.sv
// Purpose: self-checking bench for pacs_decode
// Assumes: ctrl written over APB, decode one cycle behind
// Notes: expectations worked out from the decode tables
`timescale 1ns/1ps
`default_nettype none
module pacs_decode_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] ba = 16'h0000;
  logic ex = 1'b1;
  logic [5:0] ix = 6'h00;
  logic [1:0] sp = 2'h1;
  logic [7:0] dir = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv;
  logic [7:0] kOut, kOe, pin;
  int fail_count = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  pacs_decode dut_u (.clk(clk), .sys_rst(rst), .busAddr(ba), .expandedMode(ex),
    .programPageIndex(ix), .pagePartitionSelect(sp), .portKGpioOut(7'h55),
    .portKGpioDir(dir), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portKOut(kOut), .portKOe(kOe));
  pacs_emu_model emu_u (.portKOut(kOut), .portKOe(kOe), .pinLevel(pin));
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dec(input logic [15:0] a, input logic [5:0] i, input logic [6:0] e);
    @(posedge clk) ba <= a;
    ix <= i;
    @(posedge clk);
    @(negedge clk);
    chk({pin[7], pin[5:0]} === e && kOe[7] === 1'b1 && kOe[5:0] === 6'h3f, "decode");
  endtask
  function automatic logic [6:0] exv(int al, int hd, int rg, logic [5:0] i);
    logic s;
    s = rg == 3 ? 1'b0 : rg == 2 ? (al == 0 ? 1'b0 : al == 1 ? 1'b1 : !(i >= 6'h30))
      : (al == 3 || (al == 2 && rg == 1)) ? hd[0] : 1'b1;
    return {s, rg == 2 ? i : rg == 3 ? 6'h3f : 6'h3d + 6'(rg)};
  endfunction
  task automatic t_table;
    for (int al = 0; al < 4; al++)
      for (int hd = 0; hd < 2; hd++) begin
        apb(1'b1, 12'h000, {28'h0, hd[0], al[1:0], 1'b1});
        for (int rg = 0; rg < 4; rg++)
          for (int k = 0; k < 2; k++)
            dec({rg[1:0], 14'h1234}, 6'h2f + 6'(k * 2), exv(al, hd, rg, 6'h2f + 6'(k * 2)));
      end
  endtask
  task automatic t_part;
    logic [5:0] th;
    apb(1'b1, 12'h000, 32'h0000_0005);
    for (int s = 0; s < 4; s++) begin
      th = s == 0 ? 6'h38 : s == 1 ? 6'h30 : s == 2 ? 6'h20 : 6'h00;
      @(posedge clk) sp <= s[1:0];
      dec(16'h8000, th, {1'b0, th});
      if (s < 3) dec(16'hbfff, th - 6'h01, {1'b1, th - 6'h01});
    end
  endtask
  task automatic t_pins;
    apb(1'b1, 12'h000, 32'h0000_0000);
    @(posedge clk) dir <= 8'h0f;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(kOe === 8'h0f && pin === 8'hf5, "gpio");
    apb(1'b1, 12'h000, 32'h0000_0001);
    @(posedge clk) ex <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(pin[7] === 1'b1 && kOe[7] === 1'b1 && kOe[5:0] === 6'h0f, "not expanded");
    @(posedge clk) ex <= 1'b1;
    dir <= 8'h00;
  endtask
  task automatic t_apb;
    apb(1'b0, 12'h008, 32'h0);
    chk(errv === 1'b1, "unmapped");
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk(errv === 1'b1, "stat write");
    apb(1'b0, 12'h000, 32'h0);
    chk(rdv === 32'h0000_0001 && errv === 1'b0, "stat write no effect");
    apb(1'b1, 12'h000, 32'h0000_000f);
    apb(1'b0, 12'h000, 32'h0);
    chk(rdv === 32'h0000_000f && errv === 1'b0, "ctrl read");
    apb(1'b0, 12'h004, 32'h0);
    chk(rdv === 32'h0000_0180 && errv === 1'b0, "stat read");
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(kOe === 8'h00 && kOut === 8'hff && pready === 1'b0, "reset");
    t_table;
    t_part;
    t_pins;
    t_apb;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule
`default_nettype wire
